// file: design/tx_fifo_level.sv
/*
 * Occupancy tracker for the transmit FIFO. Holds only the byte count
 * and the empty and full flags; the storage lives outside.
 * Assumes push and pop come from logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module tx_fifo_level #(
	parameter int DEPTH = usb_tx_pkg::FIFO_DEPTH
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	input  wire logic push,
	input  wire logic pop,
	input  wire logic clear,
	output logic      empty,
	output logic      full,
	output logic      overrun_evt,
	output logic      underrun_evt
);

	localparam int CW = $clog2(DEPTH + 1);

	generate
		if (DEPTH < 2)
		begin : g_check
			$error("tx_fifo_level needs DEPTH of at least 2");
		end
	endgenerate

	typedef struct packed {
		logic [CW-1:0] count;
		logic          empty;
		logic          full;
	} lvl_t;

	lvl_t r_reg;
	lvl_t r_next;

	////////////////////////////////////////////////////////////////////////
	// Next level; clear beats any push or pop in the same cycle
	always_comb
	begin
		r_next = r_reg;
		overrun_evt = 1'b0;
		underrun_evt = 1'b0;
		// Misuse is reported even during a clear, so the set is never lost
		// Push into a full FIFO with no pop in the same cycle is dropped and flagged
		if (push && r_reg.full && !pop)
			overrun_evt = ce;
		// Pop from an empty FIFO is a sender under-run
		if (pop && r_reg.empty)
			underrun_evt = ce;
		if (clear)
		begin
			r_next.count = '0;
		end
		else
		begin
			// A pop frees the slot that a push into a full FIFO takes
			if (push && (!r_reg.full || pop) && !(pop && !r_reg.empty))
				r_next.count = r_reg.count + CW'(1);
			else if (pop && !r_reg.empty &&
				!(push && (!r_reg.full || pop)))
				r_next.count = r_reg.count - CW'(1);
		end
		r_next.empty = (r_next.count == '0);
		r_next.full = (r_next.count == CW'(DEPTH));
	end

	// Level state, frozen while the clock enable is low
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r_reg.count <= '0;
			r_reg.empty <= usb_tx_pkg::RST_EMPTY;
			r_reg.full <= usb_tx_pkg::RST_FULL;
		end
		else if (ce)
			r_reg <= r_next;
	end

	assign empty = r_reg.empty;
	assign full = r_reg.full;

endmodule
`default_nettype wire

// file: design/usb_in_endpoint_tx_status.sv
/*
 * Status side of a USB IN endpoint: data toggle, answer to each IN
 * token, transaction result bits, transmit FIFO flags, interrupt and
 * an APB register slave. Assumes the packet engine on the same clock
 * gives one in_token pulse per valid IN token and one txn_done pulse
 * when that transaction ends.
 */
`timescale 1ns/100ps
`default_nettype none

module usb_in_endpoint_tx_status #(
	parameter int FIFO_DEPTH = usb_tx_pkg::FIFO_DEPTH
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        in_token,
	input  wire logic        txn_done,
	input  wire logic        txn_host_ack,
	input  wire logic        txn_error,
	input  wire logic        sender_byte_read,
	output logic             resp_valid,
	output logic      [1:0]  resp_code,
	output logic             data_pid_odd,
	output logic             fifo_flush,
	output logic             irq
);

	typedef enum logic {ST_IDLE, ST_WAIT_END} phase_t;

	typedef struct packed {
		phase_t      st;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        fifo_clear_request;
		logic        toggle_overwrite_enable;
		logic        stall_request_control;
		logic        send_packet_armed;
		logic        data_toggle_bit;
		logic        stall_status;
		logic        nack_status;
		logic        error_status;
		logic        ack_status;
		logic        resp_valid;
		logic [1:0]  resp_code;
		logic        flush;
		logic        fifo_underrun_flag;
		logic        fifo_overrun_flag;
		logic        tx_int;
		logic        int_mask;
		logic        irq;
	} regs_t;

	regs_t r_reg;
	regs_t r_next;

	logic        fifo_empty_flag;
	logic        fifo_full_flag;
	logic        ovr_evt;
	logic        und_evt;
	logic        fifo_push;
	logic        wr_done;
	logic        wr_ctl;
	logic        wr_sts;
	logic [31:0] rd_word;
	logic        rd_bad;
	logic        success;

	generate
		if (FIFO_DEPTH < 2 || FIFO_DEPTH > 1024)
		begin : g_check
			$error("FIFO_DEPTH must be 2 to 1024");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Bus decode; a write lands on the edge that samples pready high
	assign wr_done = psel && penable && pwrite && r_reg.pready;
	assign wr_ctl = wr_done && (paddr == usb_tx_pkg::OFF_CONTROL);
	assign wr_sts = wr_done && (paddr == usb_tx_pkg::OFF_STATUS);
	assign fifo_push = wr_done && (paddr == usb_tx_pkg::OFF_FIFO_DATA);

	// Success needs our data packet out, host ACK and no error
	assign success = (r_reg.st == ST_WAIT_END) && txn_done &&
		(r_reg.resp_code == usb_tx_pkg::RESP_DATA) &&
		txn_host_ack && !txn_error;

	tx_fifo_level #(
		.DEPTH (FIFO_DEPTH)
	) u_level (
		.pclk         (pclk),
		.presetn      (presetn),
		.ce           (ce),
		.push         (fifo_push),
		.pop          (sender_byte_read),
		.clear        (r_reg.flush),
		.empty        (fifo_empty_flag),
		.full         (fifo_full_flag),
		.overrun_evt  (ovr_evt),
		.underrun_evt (und_evt)
	);

	////////////////////////////////////////////////////////////////////////
	// Read mux; reserved bits read as zero
	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_bad = 1'b0;
		case (paddr)
			usb_tx_pkg::OFF_CONTROL:
			begin
				rd_word[usb_tx_pkg::CTL_CLEAR] = r_reg.fifo_clear_request;
				rd_word[usb_tx_pkg::CTL_OVERWRITE] =
					r_reg.toggle_overwrite_enable;
				rd_word[usb_tx_pkg::CTL_STALL] = r_reg.stall_request_control;
				rd_word[usb_tx_pkg::CTL_ARMED] = r_reg.send_packet_armed;
			end
			usb_tx_pkg::OFF_STATUS:
			begin
				rd_word[usb_tx_pkg::STS_TOGGLE] = r_reg.data_toggle_bit;
				rd_word[usb_tx_pkg::STS_STALL] = r_reg.stall_status;
				rd_word[usb_tx_pkg::STS_NACK] = r_reg.nack_status;
				rd_word[usb_tx_pkg::STS_ERROR] = r_reg.error_status;
				rd_word[usb_tx_pkg::STS_ACK] = r_reg.ack_status;
			end
			usb_tx_pkg::OFF_FIFO_FLAGS:
			begin
				rd_word[usb_tx_pkg::FLG_EMPTY] = fifo_empty_flag;
				rd_word[usb_tx_pkg::FLG_FULL] = fifo_full_flag;
				rd_word[usb_tx_pkg::FLG_FIFO_UNDERRUN_FLAG] = r_reg.fifo_underrun_flag;
				rd_word[usb_tx_pkg::FLG_FIFO_OVERRUN_FLAG] = r_reg.fifo_overrun_flag;
			end
			usb_tx_pkg::OFF_INT_STATUS:
				rd_word[usb_tx_pkg::INT_TX] = r_reg.tx_int;
			usb_tx_pkg::OFF_INT_MASK:
				rd_word[usb_tx_pkg::INT_TX] = r_reg.int_mask;
			usb_tx_pkg::OFF_FIFO_DATA:
				rd_word = 32'h0000_0000;
			default:
				rd_bad = 1'b1;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Next state: software writes first, hardware events after, so an
	// event in the same cycle as a software clear is never lost
	always_comb
	begin
		r_next = r_reg;
		r_next.resp_valid = 1'b0;

		// One wait state keeps pready and prdata straight from flops
		r_next.pready = psel && penable && !r_reg.pready;
		if (psel && penable && !r_reg.pready)
		begin
			r_next.prdata = pwrite ? 32'h0000_0000 : rd_word;
			r_next.pslverr = rd_bad;
		end

		// Control writes; reserved bits dropped
		if (wr_ctl)
		begin
			r_next.toggle_overwrite_enable = pwdata[usb_tx_pkg::CTL_OVERWRITE];
			r_next.stall_request_control = pwdata[usb_tx_pkg::CTL_STALL];
			r_next.send_packet_armed = pwdata[usb_tx_pkg::CTL_ARMED];
			if (pwdata[usb_tx_pkg::CTL_CLEAR])
			begin
				r_next.fifo_clear_request = 1'b1;
				r_next.send_packet_armed = 1'b0;
			end
		end

		// Status writes: only toggle (gated) and ack are writable
		if (wr_sts)
		begin
			if (r_reg.toggle_overwrite_enable)
				r_next.data_toggle_bit = pwdata[usb_tx_pkg::STS_TOGGLE];
			r_next.ack_status = pwdata[usb_tx_pkg::STS_ACK];
			if (r_reg.ack_status && !pwdata[usb_tx_pkg::STS_ACK])
				r_next.tx_int = 1'b0;
		end

		// Interrupt status is write-one-to-clear, mask is plain
		if (wr_done && paddr == usb_tx_pkg::OFF_INT_STATUS &&
			pwdata[usb_tx_pkg::INT_TX])
			r_next.tx_int = 1'b0;
		if (wr_done && paddr == usb_tx_pkg::OFF_INT_MASK)
			r_next.int_mask = pwdata[usb_tx_pkg::INT_TX];

		// FIFO clear: one cycle of flush, then the request drops
		if (r_reg.fifo_clear_request && !r_reg.flush)
			r_next.flush = 1'b1;
		if (r_reg.flush)
		begin
			r_next.flush = 1'b0;
			r_next.fifo_clear_request = 1'b0;
			r_next.fifo_underrun_flag = 1'b0;
			r_next.fifo_overrun_flag = 1'b0;
			r_next.tx_int = 1'b0;
		end
		// Clear keeps the packet disarmed while it runs
		if (r_reg.fifo_clear_request)
			r_next.send_packet_armed = 1'b0;

		// Answer the token; stall outranks NACK and data
		if (r_reg.st == ST_IDLE && in_token)
		begin
			r_next.st = ST_WAIT_END;
			r_next.resp_valid = 1'b1;
			if (r_reg.stall_request_control)
				r_next.resp_code = usb_tx_pkg::RESP_STALL;
			else if (r_reg.send_packet_armed)
				r_next.resp_code = usb_tx_pkg::RESP_DATA;
			else
				r_next.resp_code = usb_tx_pkg::RESP_NACK;
		end

		// Transaction end: stall, NACK and error bits are rewritten every time; ack is set only on success
		if (r_reg.st == ST_WAIT_END && txn_done)
		begin
			r_next.st = ST_IDLE;
			r_next.stall_status =
				(r_reg.resp_code == usb_tx_pkg::RESP_STALL);
			r_next.nack_status =
				(r_reg.resp_code == usb_tx_pkg::RESP_NACK);
			r_next.error_status = txn_error;
		end
		if (success)
		begin
			r_next.data_toggle_bit = !r_reg.data_toggle_bit;
			r_next.ack_status = 1'b1;
			r_next.tx_int = 1'b1;
			r_next.send_packet_armed = 1'b0;
		end

		// FIFO misuse flags; only a FIFO clear brings them down
		if (und_evt)
		begin
			r_next.fifo_underrun_flag = 1'b1;
			r_next.tx_int = 1'b1;
		end
		if (ovr_evt)
		begin
			r_next.fifo_overrun_flag = 1'b1;
			r_next.tx_int = 1'b1;
		end

		r_next.irq = r_next.tx_int && r_next.int_mask;
	end

	////////////////////////////////////////////////////////////////////////
	// All state but the FIFO level (held in u_level) in one register, frozen while the clock enable is low
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r_reg <= '0;
			r_reg.st <= ST_IDLE;
			r_reg.data_toggle_bit <= usb_tx_pkg::RST_BIT;
		end
		else if (ce)
			r_reg <= r_next;
	end

	// Outputs come straight from the register
	assign prdata = r_reg.prdata;
	assign pready = r_reg.pready;
	assign pslverr = r_reg.pslverr;
	assign resp_valid = r_reg.resp_valid;
	assign resp_code = r_reg.resp_code;
	assign data_pid_odd = r_reg.data_toggle_bit;
	assign fifo_flush = r_reg.flush;
	assign irq = r_reg.irq;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	logic token_taken;
	assign token_taken = ce && in_token && r_reg.st == ST_IDLE;

	a_stall_answer: assert property (
		token_taken && r_reg.stall_request_control
		|=> resp_valid && resp_code == usb_tx_pkg::RESP_STALL)
		else $error("stall control did not give a STALL answer");

	a_nack_answer: assert property (
		token_taken && !r_reg.stall_request_control &&
		!r_reg.send_packet_armed
		|=> resp_valid && resp_code == usb_tx_pkg::RESP_NACK)
		else $error("no packet ready did not give a NACK answer");

	a_data_pid: assert property (
		resp_valid && resp_code == usb_tx_pkg::RESP_DATA
		|-> data_pid_odd == r_reg.data_toggle_bit &&
		$past(r_reg.send_packet_armed))
		else $error("data answer without armed packet");

	a_toggle_flip: assert property (
		ce && success |=> data_pid_odd != $past(data_pid_odd))
		else $error("toggle did not invert after success");

	a_toggle_locked: assert property (
		ce && wr_sts && !r_reg.toggle_overwrite_enable && !success
		|=> $stable(r_reg.data_toggle_bit))
		else $error("toggle written without overwrite enable");

	a_result_bits: assert property (
		ce && r_reg.st == ST_WAIT_END && txn_done
		|=> r_reg.stall_status ==
		($past(resp_code) == usb_tx_pkg::RESP_STALL) &&
		r_reg.nack_status == ($past(resp_code) == usb_tx_pkg::RESP_NACK))
		else $error("stall or nack status wrong after transaction");

	a_error_bit: assert property (
		ce && r_reg.st == ST_WAIT_END && txn_done
		|=> r_reg.error_status == $past(txn_error))
		else $error("error status wrong after transaction");

	a_ack_int: assert property (
		ce && success |=> r_reg.ack_status && r_reg.tx_int &&
		!r_reg.send_packet_armed ##1 (irq == r_reg.int_mask || !ce))
		else $error("ack did not raise interrupt or drop armed bit");

	a_overrun_flag: assert property (
		ce && fifo_push && fifo_full_flag && !sender_byte_read
		|=> r_reg.fifo_overrun_flag && r_reg.tx_int)
		else $error("write to full FIFO not flagged");

	sequence s_flush;
		ce && r_reg.flush && !und_evt && !ovr_evt;
	endsequence

	sequence s_cleaned;
		!r_reg.fifo_clear_request && !r_reg.fifo_underrun_flag &&
		!r_reg.fifo_overrun_flag && fifo_empty_flag && !fifo_full_flag;
	endsequence

	a_clear_done: assert property (
		s_flush |=> s_cleaned)
		else $error("FIFO clear did not finish cleanly");

endmodule
`default_nettype wire

// file: design/usb_tx_pkg.sv
/*
 * Constants for the IN endpoint transmit status block: register
 * offsets, field positions, reset values and response encodings.
 * Assumes a 32-bit APB register bus with byte addressing.
 */
package usb_tx_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_CONTROL    = 8'h00;
	localparam logic [7:0] OFF_STATUS     = 8'h04;
	localparam logic [7:0] OFF_FIFO_FLAGS = 8'h08;
	localparam logic [7:0] OFF_INT_STATUS = 8'h0c;
	localparam logic [7:0] OFF_INT_MASK   = 8'h10;
	localparam logic [7:0] OFF_FIFO_DATA  = 8'h14;

	// Control register fields
	localparam int CTL_CLEAR     = 7;
	localparam int CTL_OVERWRITE = 6;
	localparam int CTL_STALL     = 3;
	localparam int CTL_ARMED     = 1;

	// Result status register fields
	localparam int STS_TOGGLE = 7;
	localparam int STS_STALL  = 3;
	localparam int STS_NACK   = 2;
	localparam int STS_ERROR  = 1;
	localparam int STS_ACK    = 0;

	// FIFO flags register fields
	localparam int FLG_EMPTY = 3;
	localparam int FLG_FULL  = 2;
	localparam int FLG_FIFO_UNDERRUN_FLAG  = 1;
	localparam int FLG_FIFO_OVERRUN_FLAG  = 0;

	// Interrupt status and mask field
	localparam int INT_TX = 0;

	// Reset values
	localparam logic RST_EMPTY = 1'b1;
	localparam logic RST_FULL  = 1'b0;
	localparam logic RST_BIT   = 1'b0;

	// Answer to an IN token
	localparam logic [1:0] RESP_DATA  = 2'h0;
	localparam logic [1:0] RESP_NACK  = 2'h1;
	localparam logic [1:0] RESP_STALL = 2'h2;

	// Default transmit FIFO depth in bytes
	localparam int FIFO_DEPTH = 8;

endpackage

// file: tb/test_usb_in_endpoint_tx_status.sv
/*
 * Self-checking bench for the IN endpoint transmit status block.
 * Assumes the design package, the design and usb_host_model are
 * compiled first; the host model drives the USB side.
 */
`timescale 1ns/100ps
`default_nettype none

module test_usb_in_endpoint_tx_status;
	localparam int DEPTH = 4;

	logic        pclk;
	logic        presetn;
	logic        ce;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        in_token;
	logic        txn_done;
	logic        txn_host_ack;
	logic        txn_error;
	logic        sender_byte_read;
	logic        resp_valid;
	logic [1:0]  resp_code;
	logic        data_pid_odd;
	logic        fifo_flush;
	logic        irq;
	int          n_mismatch;
	int          n_checks;
	int          n_flush;
	logic [32:0] rd_q[$];
	logic [2:0]  resp_q[$];

	// Small FIFO keeps the fill loop short
	usb_in_endpoint_tx_status #(.FIFO_DEPTH(DEPTH))
		usb_in_endpoint_tx_status_i (.pclk, .presetn, .ce, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.in_token, .txn_done, .txn_host_ack, .txn_error, .sender_byte_read,
		.resp_valid, .resp_code, .data_pid_odd, .fifo_flush, .irq);

	usb_host_model usb_host_model_i (.pclk, .resp_valid, .resp_code,
		.in_token, .txn_done, .txn_host_ack, .txn_error, .sender_byte_read);

	// 25 MHz clock
	initial
		pclk = 1'b0;
	always #20 pclk = ~pclk;

	////////////////////////////////////////////////////////////////////
	task automatic cmp(input string what, input logic [32:0] e,
		input logic [32:0] g);
		n_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic close_out;
		// A note never matched means a result never came
		if (rd_q.size() != 0 || resp_q.size() != 0)
			n_mismatch++;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			n_mismatch++;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	// Expected read noted as {pslverr, prdata}
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		rd_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic tok(input logic pid, input logic [1:0] code,
		input logic ack, input logic err, input int pops);
		resp_q.push_back({pid, code});
		usb_host_model_i.in_txn(ack, err, pops, $urandom_range(3));
	endtask

	// Level sampled mid-cycle, clear of edge updates
	task automatic irq_is(input logic e);
		@(negedge pclk);
		cmp("irq", {32'h0, e}, {32'h0, irq});
		@(posedge pclk);
	endtask

	task automatic endt(input string s);
		$display("test %s done", s);
	endtask

	////////////////////////////////////////////////////////////////////
	// Results matched against notes in arrival order
	always @(posedge pclk)
	begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			cmp("read", rd_q.pop_front(), {pslverr, prdata});
		if (resp_valid === 1'b1)
			cmp("answer", {30'h0, resp_q.pop_front()},
				{30'h0, data_pid_odd, resp_code});
		if (fifo_flush === 1'b1)
			n_flush++;
	end

	// Watchdog well beyond the expected run
	initial
	begin
		#2000000;
		n_mismatch++;
		close_out();
	end

	// Main sequence
	initial
	begin
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		n_mismatch = 0;
		n_checks = 0;
		n_flush = 0;
		void'($urandom(90));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(usb_tx_pkg::OFF_CONTROL, 33'h0);
		rd(usb_tx_pkg::OFF_STATUS, 33'h0);
		rd(usb_tx_pkg::OFF_FIFO_FLAGS, 33'h8);
		rd(usb_tx_pkg::OFF_INT_STATUS, 33'h0);
		rd(8'h40, 33'h1_0000_0000);
		wr(usb_tx_pkg::OFF_INT_MASK, 32'h1);
		endt("reset");
		tok(1'b0, usb_tx_pkg::RESP_NACK, 1'b0, 1'b0, 0);
		rd(usb_tx_pkg::OFF_STATUS, 33'h4);
		wr(usb_tx_pkg::OFF_CONTROL, 32'h0a);
		tok(1'b0, usb_tx_pkg::RESP_STALL, 1'b0, 1'b0, 0);
		rd(usb_tx_pkg::OFF_STATUS, 33'h8);
		endt("nack_stall");
		wr(usb_tx_pkg::OFF_FIFO_DATA, $urandom_range(255));
		rd(usb_tx_pkg::OFF_FIFO_FLAGS, 33'h0);
		wr(usb_tx_pkg::OFF_CONTROL, 32'h02);
		tok(1'b0, usb_tx_pkg::RESP_DATA, 1'b1, 1'b0, 1);
		rd(usb_tx_pkg::OFF_STATUS, 33'h81);
		rd(usb_tx_pkg::OFF_CONTROL, 33'h0);
		rd(usb_tx_pkg::OFF_FIFO_FLAGS, 33'h8);
		irq_is(1'b1);
		wr(usb_tx_pkg::OFF_INT_MASK, 32'h0);
		irq_is(1'b0);
		wr(usb_tx_pkg::OFF_INT_MASK, 32'h1);
		// Toggle 0 and read-only bits written without overwrite enable
		wr(usb_tx_pkg::OFF_STATUS, 32'h0e);
		rd(usb_tx_pkg::OFF_STATUS, 33'h80);
		irq_is(1'b0);
		endt("ack");
		wr(usb_tx_pkg::OFF_FIFO_DATA, $urandom_range(255));
		wr(usb_tx_pkg::OFF_CONTROL, 32'h02);
		// Host ack with an error is not a success
		tok(1'b1, usb_tx_pkg::RESP_DATA, 1'b1, 1'b1, 1);
		rd(usb_tx_pkg::OFF_STATUS, 33'h82);
		wr(usb_tx_pkg::OFF_CONTROL, 32'h40);
		wr(usb_tx_pkg::OFF_STATUS, 32'h00);
		rd(usb_tx_pkg::OFF_STATUS, 33'h02);
		wr(usb_tx_pkg::OFF_CONTROL, 32'h00);
		repeat (3)
			tok(1'b0, usb_tx_pkg::RESP_NACK, 1'b0, 1'b0, 0);
		rd(usb_tx_pkg::OFF_STATUS, 33'h04);
		endt("error_toggle");
		repeat (DEPTH)
			wr(usb_tx_pkg::OFF_FIFO_DATA, $urandom_range(255));
		rd(usb_tx_pkg::OFF_FIFO_FLAGS, 33'h4);
		wr(usb_tx_pkg::OFF_FIFO_DATA, $urandom_range(255));
		rd(usb_tx_pkg::OFF_FIFO_FLAGS, 33'h5);
		wr(usb_tx_pkg::OFF_FIFO_FLAGS, 32'h0);
		rd(usb_tx_pkg::OFF_FIFO_FLAGS, 33'h5);
		rd(usb_tx_pkg::OFF_INT_STATUS, 33'h1);
		irq_is(1'b1);
		wr(usb_tx_pkg::OFF_INT_STATUS, 32'h1);
		rd(usb_tx_pkg::OFF_INT_STATUS, 33'h0);
		wr(usb_tx_pkg::OFF_CONTROL, 32'h82);
		rd(usb_tx_pkg::OFF_CONTROL, 33'h0);
		rd(usb_tx_pkg::OFF_FIFO_FLAGS, 33'h8);
		cmp("flush", 33'h1, 33'(n_flush));
		endt("overrun");
		wr(usb_tx_pkg::OFF_CONTROL, 32'h02);
		tok(1'b0, usb_tx_pkg::RESP_DATA, 1'b0, 1'b1, 1);
		rd(usb_tx_pkg::OFF_FIFO_FLAGS, 33'ha);
		irq_is(1'b1);
		// Frozen block keeps its interrupt and leaves the bus waiting
		ce <= 1'b0;
		fork
			wr(usb_tx_pkg::OFF_INT_MASK, 32'h0);
			begin
				repeat (5) @(posedge pclk);
				cmp("frozen", 33'h1, {31'h0, pready, irq});
				ce <= 1'b1;
			end
		join
		irq_is(1'b0);
		wr(usb_tx_pkg::OFF_INT_MASK, 32'h1);
		wr(usb_tx_pkg::OFF_CONTROL, 32'h80);
		rd(usb_tx_pkg::OFF_FIFO_FLAGS, 33'h8);
		rd(usb_tx_pkg::OFF_INT_STATUS, 33'h0);
		irq_is(1'b0);
		cmp("flush", 33'h2, 33'(n_flush));
		endt("underrun");
		close_out();
	end
endmodule

`default_nettype wire

// file: tb/usb_host_model.sv
/*
 * Behavioural USB host for the IN endpoint: issues IN tokens, pops
 * FIFO bytes after a data answer and closes each transaction.
 * Assumes in_txn is called right after a rising pclk edge.
 */
`timescale 1ns/100ps
`default_nettype none

module usb_host_model (
	input  wire logic       pclk,
	input  wire logic       resp_valid,
	input  wire logic [1:0] resp_code,
	output logic            in_token,
	output logic            txn_done,
	output logic            txn_host_ack,
	output logic            txn_error,
	output logic            sender_byte_read
);
	logic ack_r;
	logic err_r;
	logic junk;

	// Quiet lines at time zero
	initial
	begin
		in_token = 1'b0;
		txn_done = 1'b0;
		sender_byte_read = 1'b0;
		ack_r = 1'b0;
		err_r = 1'b0;
		junk = 1'b0;
	end

	// Result lines carry junk outside the done cycle, so a stale sample
	// in the design shows up
	always @(posedge pclk)
		junk <= ~junk;
	assign txn_host_ack = txn_done ? ack_r : junk;
	assign txn_error    = txn_done ? err_r : ~junk;

	// One IN transaction; never two open at once
	task automatic in_txn(input logic ack, input logic err,
		input int pops, input int gap);
		int n;
		in_token <= 1'b1;
		@(posedge pclk);
		in_token <= 1'b0;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (resp_valid !== 1'b1 && n < 20);
		// Bytes leave the FIFO only after a data answer
		if (resp_code === usb_tx_pkg::RESP_DATA)
		begin
			repeat (pops)
			begin
				sender_byte_read <= 1'b1;
				@(posedge pclk);
			end
			sender_byte_read <= 1'b0;
		end
		repeat (gap) @(posedge pclk);
		ack_r <= ack;
		err_r <= err;
		txn_done <= 1'b1;
		@(posedge pclk);
		txn_done <= 1'b0;
	endtask
endmodule

`default_nettype wire
